/* verilog/ccp_consts.vh */
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define CCP_IDX_VALUE1     14'h040c
`define CCP_IDX_CONTROL1   14'h040e
`define CCP_IDX_TRIGGER1   14'h040f
`define CCP_IDX_VALUE2     14'h0410
`define CCP_IDX_CONTROL2   14'h0412
`define CCP_IDX_TRIGGER2   14'h0413
`define CCP_IDX_TIMER_SEL  14'h041f

// control register fields
`define CCP_CTL_ENABLE     7
`define CCP_CTL_OUT        5
`define CCP_CTL_ALIGN      4
`define CCP_CTL_MODE_HI    3
`define CCP_CTL_MODE_LO    0

// mode codes
`define CCP_MODE_OFF       4'h0
`define CCP_MODE_TOG_CLR   4'h1
`define CCP_MODE_TOGGLE    4'h2
`define CCP_MODE_CAP_ANY   4'h3
`define CCP_MODE_CAP_FALL  4'h4
`define CCP_MODE_CAP_RISE  4'h5
`define CCP_MODE_CAP_RISE4 4'h6
`define CCP_MODE_CAP_RISE16 4'h7
`define CCP_MODE_SET       4'h8
`define CCP_MODE_CLEAR     4'h9
`define CCP_MODE_PULSE     4'ha
`define CCP_MODE_PULSE_CLR 4'hb
`define CCP_MODE_PWM_MASK  4'hc

// trigger source codes
`define CCP_SRC_PIN        4'h0
`define CCP_SRC_CMP1       4'h1
`define CCP_SRC_CMP2       4'h2
`define CCP_SRC_PINCHG     4'h3
`define CCP_SRC_CELL_BASE  4'h4
`define CCP_SRC_BLOCK_BASE 4'h8
`define CCP_SRC_BLOCK_LAST 4'hc

// timer selection
`define CCP_TSEL_VALID     2'h1
`define CCP_TSEL_RESET     8'h05

// reset values
`define CCP_CTL_RESET      8'h00
`define CCP_TRIG_RESET     4'h0

// edge prescale terminal counts
`define CCP_PRESC_4        4'h3
`define CCP_PRESC_16       4'hf

`endif

/* verilog/ccp_capture_detect.v */
`timescale 1ns/1ps
`default_nettype none
`include "ccp_consts.vh"

// picks the capture source and turns its edges into one-cycle capture events
module ccp_capture_detect (
    input  wire        clk, // system clock
    input  wire        reset, // async reset, active high
    input  wire        active, // channel enabled in a capture mode
    input  wire [3:0]  mode, // channel mode code
    input  wire [3:0]  src_sel, // trigger source code
    input  wire        pin_in, // assigned capture pin
    input  wire        cmp_one, // comparator one output
    input  wire        cmp_two, // comparator two output
    input  wire        pin_change, // pin-change interrupt
    input  wire [3:0]  cell_out, // logic cell outputs one to four
    input  wire [4:0]  block_sig, // logic block signals 14 to 18
    output reg         capture_evt // one-cycle capture strobe
);

    reg        src_level;   // selected source, combinational
    reg        prev_reg;    // source level one cycle ago
    reg  [3:0] presc_reg;   // rising edge prescale counter
    reg  [3:0] presc_next;
    reg        fire;        // event qualifies this cycle
    wire       rise;
    wire       fall;

    // source mux; reserved codes read as a quiet low level
    always @* begin
        src_level = 1'b0;
        if (src_sel == `CCP_SRC_PIN) begin
            src_level = pin_in;
        end else if (src_sel == `CCP_SRC_CMP1) begin
            src_level = cmp_one;
        end else if (src_sel == `CCP_SRC_CMP2) begin
            src_level = cmp_two;
        end else if (src_sel == `CCP_SRC_PINCHG) begin
            src_level = pin_change;
        end else if (src_sel < `CCP_SRC_BLOCK_BASE) begin
            src_level = cell_out[src_sel[1:0]];
        end else if (src_sel <= `CCP_SRC_BLOCK_LAST) begin
            src_level = block_sig[src_sel[2:0]];
        end
    end

    assign rise = src_level & ~prev_reg;
    assign fall = ~src_level & prev_reg;

    // edge qualification per mode
    always @* begin
        fire       = 1'b0;
        presc_next = presc_reg;
        case (mode)
            `CCP_MODE_CAP_ANY: fire = rise | fall;
            `CCP_MODE_CAP_FALL: fire = fall;
            `CCP_MODE_CAP_RISE: fire = rise;
            `CCP_MODE_CAP_RISE4: begin
                if (rise) begin
                    fire       = (presc_reg == `CCP_PRESC_4);
                    presc_next = fire ? 4'h0 : presc_reg + 4'h1;
                end
            end
            `CCP_MODE_CAP_RISE16: begin
                if (rise) begin
                    fire       = (presc_reg == `CCP_PRESC_16);
                    presc_next = presc_reg + 4'h1;
                end
            end
            default: presc_next = 4'h0;
        endcase
        // counter restarts whenever the channel leaves capture; a change between
        // capture modes keeps the partial count
        if (!active) begin
            fire       = 1'b0;
            presc_next = 4'h0;
        end
    end

    // edge history, prescaler and event strobe
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prev_reg    <= 1'b0;
            presc_reg   <= 4'h0;
            capture_evt <= 1'b0;
        end else begin
            prev_reg    <= src_level;
            presc_reg   <= presc_next;
            capture_evt <= fire;
        end
    end

endmodule
`default_nettype wire

/* verilog/ccp_unit.v */
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_consts.vh"

// Behaviour
// - control bit 7 enables channel, resets low
// - control bit 5 reads output level only
// - bit 4 picks PWM duty alignment
// - mode 11xx is PWM, 0000 off, flags
// - 1010 pulses output, 1011 also clears timer
// - 0010 toggles output, 0001 also clears timer
// - capture on any, falling, rising edge
// - capture every fourth or sixteenth rising edge
// - 1000 sets, 1001 clears; released by off
// - clear the channel's selected timer on match
// - trigger selector routes capture source
// - value register split high and low byte
// - right aligned duty in low ten bits
// - left aligned duty in top ten bits
// - value register has no reset
// - two-bit timer selector, only 01 valid
// - channel one bits 1:0, two 3:2
// - default selection is the valid timers
// - period wrap reloads shadow duty buffer
// - PWM output high at period start, unless zero
// - PWM output low at duty match
module ccp_unit (
    input  wire        clk, // system clock, 40 MHz
    input  wire        reset, // async reset, active high
    // apb slave
    input  wire        psel, // slave select
    input  wire        penable, // access phase
    input  wire        pwrite, // write when high
    input  wire [15:0] paddr, // byte address
    input  wire [31:0] pwdata, // write data
    input  wire [3:0]  pstrb, // write byte lanes
    output reg  [31:0] prdata, // read data
    output reg         pready, // transfer done
    output reg         pslverr, // unmapped address
    // timers
    input  wire [15:0] sixteen_bit_timer, // 16-bit timer count
    input  wire [7:0]  period_timer_count, // 8-bit period timer count
    input  wire [7:0]  period_value, // period register of that timer
    input  wire [1:0]  period_fine_bits, // two low bits of time base
    input  wire        period_timer_inc, // period timer increment strobe
    output reg         sixteen_bit_timer_clear, // clear 16-bit timer, pulse
    output reg         period_timer_clear, // clear period timer, pulse
    // capture sources
    input  wire [1:0]  capture_pin, // assigned pin per channel
    input  wire        comparator_one_output, // comparator one
    input  wire        comparator_two_output, // comparator two
    input  wire        pin_change_interrupt, // pin-change interrupt
    input  wire [3:0]  logic_cell_output, // logic cells one to four
    input  wire [4:0]  logic_block_signal, // logic block signals 14 to 18
    // channel results
    output wire [1:0]  channel_out, // channel output levels
    output wire [1:0]  channel_interrupt_flag // flag set pulse per channel
);

    // apb phases
    wire        setup_ph = psel & ~penable;
    wire        wr_acc   = psel & penable & pready & pwrite & (paddr[1:0] == 2'h0);
    wire [13:0] widx     = paddr[15:2];

    // shared timer selection register, channel one low, channel two above
    reg  [7:0]  timer_select_register;
    wire [1:0]  clr16_req;      // per channel timer clear request
    wire [1:0]  pclr_req;       // per channel period wrap seen

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : ch
            localparam [13:0] IDX_VAL = (i == 0) ? `CCP_IDX_VALUE1 : `CCP_IDX_VALUE2;
            localparam [13:0] IDX_CTL = (i == 0) ? `CCP_IDX_CONTROL1 : `CCP_IDX_CONTROL2;
            localparam [13:0] IDX_TRG = (i == 0) ? `CCP_IDX_TRIGGER1 : `CCP_IDX_TRIGGER2;

            reg  [15:0] channel_value; // capture or compare value
            reg         enable_reg; // channel enable
            reg         align_reg; // duty alignment, 1 = left
            reg  [3:0]  mode_reg; // mode code
            reg  [3:0]  trig_reg; // trigger source code
            reg         out_reg; // channel output level
            reg         flag_reg; // interrupt flag set pulse
            reg         match_prev_reg; // equality seen last cycle
            reg  [9:0]  shadow_reg; // buffered pwm duty
            reg         out_next;
            reg         flag_next;
            reg         clr_next;

            wire [1:0]  tsel = timer_select_register[2*i+1:2*i];
            wire        timer_ok = (tsel == `CCP_TSEL_VALID);
            wire        is_pwm = ((mode_reg & `CCP_MODE_PWM_MASK)
                                  == `CCP_MODE_PWM_MASK);
            wire        is_cap = (mode_reg >= `CCP_MODE_CAP_ANY)
                                 && (mode_reg <= `CCP_MODE_CAP_RISE16);
            wire        run = enable_reg && (mode_reg != `CCP_MODE_OFF)
                              && timer_ok;
            // duty picked out of the value register by alignment
            wire [9:0]  duty = align_reg ? {channel_value[15:8], channel_value[7:6]}
                                         : channel_value[9:0];
            wire        wrap = period_timer_inc
                               && (period_timer_count == period_value);
            wire [9:0]  timebase = {period_timer_count, period_fine_bits};
            wire        equal = (sixteen_bit_timer == channel_value);
            wire        match = equal && !match_prev_reg;
            wire        cap_evt;

            ccp_capture_detect u_det (
                .clk         (clk),
                .reset       (reset),
                .active      (run && is_cap),
                .mode        (mode_reg),
                .src_sel     (trig_reg),
                .pin_in      (capture_pin[i]),
                .cmp_one     (comparator_one_output),
                .cmp_two     (comparator_two_output),
                .pin_change  (pin_change_interrupt),
                .cell_out    (logic_cell_output),
                .block_sig   (logic_block_signal),
                .capture_evt (cap_evt)
            );

            // output, flag and timer clear decisions
            always @* begin
                out_next  = out_reg;
                flag_next = 1'b0;
                clr_next  = 1'b0;
                if (!run) begin
                    // leaving a compare mode releases its held level
                    out_next = 1'b0;
                end else if (is_pwm) begin
                    if (wrap) begin
                        out_next  = (duty != 10'h000);
                        flag_next = 1'b1;
                    // one step ahead, so the registered low lands on the match
                    end else if (timebase + 10'h001 == shadow_reg) begin
                        out_next = 1'b0;
                    end
                end else if (is_cap) begin
                    flag_next = cap_evt;
                end else begin
                    if (mode_reg == `CCP_MODE_PULSE || mode_reg == `CCP_MODE_PULSE_CLR) begin
                        out_next = match;
                    end
                    if (match) begin
                        flag_next = 1'b1;
                        case (mode_reg)
                            `CCP_MODE_TOGGLE: out_next = ~out_reg;
                            `CCP_MODE_TOG_CLR: begin
                                out_next = ~out_reg;
                                clr_next = 1'b1;
                            end
                            `CCP_MODE_SET: out_next = 1'b1;
                            `CCP_MODE_CLEAR: out_next = 1'b0;
                            `CCP_MODE_PULSE_CLR: clr_next = 1'b1;
                            default: clr_next = 1'b0;
                        endcase
                    end
                end
            end

            assign clr16_req[i] = clr_next;
            assign pclr_req[i]  = run && is_pwm && wrap;
            assign channel_out[i] = out_reg;
            assign channel_interrupt_flag[i] = flag_reg;

            // control, trigger, output state
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    enable_reg     <= 1'b0;
                    align_reg      <= 1'b0;
                    mode_reg       <= `CCP_MODE_OFF;
                    trig_reg       <= `CCP_TRIG_RESET;
                    out_reg        <= 1'b0;
                    flag_reg       <= 1'b0;
                    match_prev_reg <= 1'b0;
                    shadow_reg     <= 10'h000;
                end else begin
                    out_reg        <= out_next;
                    flag_reg       <= flag_next;
                    match_prev_reg <= equal;
                    if (run && is_pwm && wrap) begin
                        shadow_reg <= duty;
                    end
                    if (wr_acc && widx == IDX_CTL && pstrb[0]) begin
                        // output bit is ignored on write
                        enable_reg <= pwdata[`CCP_CTL_ENABLE];
                        align_reg  <= pwdata[`CCP_CTL_ALIGN];
                        mode_reg   <= pwdata[`CCP_CTL_MODE_HI:`CCP_CTL_MODE_LO];
                    end
                    if (wr_acc && widx == IDX_TRG && pstrb[0]) begin
                        trig_reg <= pwdata[3:0];
                    end
                end
            end

            // value register has no reset so its contents survive resets;
            // capture has priority over a same-cycle software write
            always @(posedge clk) begin
                if (cap_evt && run && is_cap) begin
                    channel_value <= sixteen_bit_timer;
                end else if (wr_acc && widx == IDX_VAL) begin
                    if (pstrb[0]) begin
                        channel_value[7:0] <= pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        channel_value[15:8] <= pwdata[15:8];
                    end
                end
            end
        end
    endgenerate

    // read mux, decoded in the setup phase so data stands in the access phase
    reg [31:0] rd_next;
    reg        hit;
    always @* begin
        rd_next = 32'h0000_0000;
        hit     = 1'b1;
        case (widx)
            `CCP_IDX_VALUE1:   rd_next = {16'h0000, ch[0].channel_value};
            `CCP_IDX_CONTROL1: rd_next = {24'h000000, ch[0].enable_reg, 1'b0,
                                          ch[0].out_reg, ch[0].align_reg,
                                          ch[0].mode_reg};
            `CCP_IDX_TRIGGER1: rd_next = {28'h0000000, ch[0].trig_reg};
            `CCP_IDX_VALUE2:   rd_next = {16'h0000, ch[1].channel_value};
            `CCP_IDX_CONTROL2: rd_next = {24'h000000, ch[1].enable_reg, 1'b0,
                                          ch[1].out_reg, ch[1].align_reg,
                                          ch[1].mode_reg};
            `CCP_IDX_TRIGGER2: rd_next = {28'h0000000, ch[1].trig_reg};
            `CCP_IDX_TIMER_SEL: rd_next = {24'h000000, timer_select_register};
            default:           hit = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit     = 1'b0;
            rd_next = 32'h0000_0000;
        end
    end

    // apb response: always one wait-free access phase after setup
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit;
            if (setup_ph && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // timer selection register and shared timer clear strobes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_select_register   <= `CCP_TSEL_RESET;
            sixteen_bit_timer_clear <= 1'b0;
            period_timer_clear      <= 1'b0;
        end else begin
            // both channels share one timer, so a clear from either wins
            sixteen_bit_timer_clear <= |clr16_req;
            period_timer_clear      <= |pclr_req;
            if (wr_acc && widx == `CCP_IDX_TIMER_SEL && pstrb[0]) begin
                timer_select_register <= {4'h0, pwdata[3:0]};
            end
        end
    end

endmodule
`default_nettype wire

/* tb/ccp_unit_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// port watcher: bus handshake, pulse widths and timer clears
module ccp_unit_monitor (
    input wire logic       clk, // system clock
    input wire logic       reset, // async reset
    input wire logic       psel, // apb select
    input wire logic       penable, // apb access
    input wire logic       pready, // apb done
    input wire logic       pslverr, // apb error
    input wire logic [7:0] period_timer_count, // period count
    input wire logic [7:0] period_value, // period
    input wire logic       period_timer_inc, // increment strobe
    input wire logic       sixteen_bit_timer_clear, // clear pulse
    input wire logic       period_timer_clear, // wrap pulse
    input wire logic [1:0] channel_out, // outputs
    input wire logic [1:0] channel_interrupt_flag // flag pulses
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_rdy; psel && !penable |=> pready && psel && penable; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_tclr; sixteen_bit_timer_clear |=> !sixteen_bit_timer_clear; endproperty
    a_tclr: assert property (p_tclr) else $error("timer clear too long");
    // the wrap pulse follows the increment that found count equal to period
    property p_wrap; period_timer_clear |->
        $past(period_timer_inc) && $past(period_timer_count) == $past(period_value); endproperty
    a_wrap: assert property (p_wrap) else $error("wrap pulse without wrap");
    property p_pflag; period_timer_clear |-> channel_interrupt_flag != 2'b00; endproperty
    a_pflag: assert property (p_pflag) else $error("no flag at period");
    property p_flag; channel_interrupt_flag[0] |=> !channel_interrupt_flag[0]; endproperty
    a_flag: assert property (p_flag) else $error("flag pulse too long");
    property p_rst; $fell(reset) |-> channel_out == 2'b00 && channel_interrupt_flag == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle");
endmodule
`default_nettype wire

/* tb/ccp_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: free 16-bit timer and 8-bit period timer with fine bits
module ccp_far_model (
    input  wire logic        clk,   // system clock
    input  wire logic        reset, // async reset
    input  wire logic        run,   // 16-bit timer counts when high
    input  wire logic        clr,   // clear pulse from the unit
    output logic      [15:0] tmr,   // 16-bit count
    output logic      [7:0]  pcnt,  // period count
    output logic      [1:0]  fine,  // time base low bits
    output logic             pinc   // increment strobe
);
    localparam logic [7:0] PR = 8'h03; // short period keeps runs brief
    assign pinc = fine == 2'h3;
    // a clear from the unit beats counting
    always @(posedge clk or posedge reset) begin
        if (reset)
            tmr <= 16'h0000;
        else if (clr)
            tmr <= 16'h0000;
        else if (run)
            tmr <= tmr + 16'h0001;
    end
    // wraps on the increment after count equals period
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            fine <= 2'h0;
            pcnt <= 8'h00;
        end else begin
            fine <= fine + 2'h1;
            if (pinc)
                pcnt <= pcnt == PR ? 8'h00 : pcnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* tb/test_capture_compare_pwm_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccp_consts.vh"
// drives the unit over apb and its capture sources, judges the outputs
module test_capture_compare_pwm_control;
    localparam logic [15:0] VAL = {`CCP_IDX_VALUE1, 2'b00};    // value address
    localparam logic [15:0] CTL = {`CCP_IDX_CONTROL1, 2'b00};  // control
    localparam logic [15:0] TRG = {`CCP_IDX_TRIGGER1, 2'b00};  // trigger source
    localparam logic [15:0] TSL = {`CCP_IDX_TIMER_SEL, 2'b00}; // timer select
    logic        clk = 1'b0, reset = 1'b1, run = 1'b0; // clock, reset, timer run
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
    logic [15:0] paddr = 16'h0000; // apb address
    logic [31:0] pwdata = 32'h0, prdata, rdat; // apb data, last read
    logic [3:0]  pstrb = 4'h0; // byte lanes
    logic        pready, pslverr, rerr, pinc, tclr, pclr; // handshake, strobes
    logic [15:0] tmr; // 16-bit timer
    logic [7:0]  pcnt; // period count
    logic [1:0]  fine, cout, flag; // time base, outputs, flags
    logic [12:0] src = 13'h0; // pin, comparators, cells
    int          num_errors = 0, tests_run = 0, n_flag, n_hi, n_tog, n_clr, acc;
    always #12.5 clk = ~clk;
    // period value matches the far model's period
    ccp_unit i_ccp_unit (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sixteen_bit_timer(tmr), .period_timer_count(pcnt),
        .period_value(8'h03), .period_fine_bits(fine), .period_timer_inc(pinc),
        .sixteen_bit_timer_clear(tclr), .period_timer_clear(pclr), .capture_pin({1'b0, src[0]}),
        .comparator_one_output(src[1]), .comparator_two_output(src[2]),
        .pin_change_interrupt(src[3]), .logic_cell_output(src[7:4]),
        .logic_block_signal(src[12:8]), .channel_out(cout), .channel_interrupt_flag(flag));
    ccp_far_model i_ccp_far_model (.clk(clk), .reset(reset), .run(run), .clr(tclr),
        .tmr(tmr), .pcnt(pcnt), .fine(fine), .pinc(pinc));
    // compares one value and counts it
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the request holds until ready is seen at an edge
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20)
            num_errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // word write with both lanes
    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h3);
    endtask
    // read into rdat
    task rd(input logic [15:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask
    // counts flags, high cycles, output changes and timer clears
    task watch(input int cyc);
        logic prev;
        {n_flag, n_hi, n_tog, n_clr} = 0;
        @(negedge clk);
        prev = cout[0];
        repeat (cyc) begin
            @(negedge clk);
            n_flag += flag[0];
            n_hi += cout[0];
            n_tog += cout[0] != prev;
            n_clr += tclr;
            prev = cout[0];
        end
    endtask
    // sets the source lines at an edge and watches
    task step(input logic [12:0] v);
        @(posedge clk);
        src <= v;
        watch(5);
    endtask
    // reset values, read-only output bit, byte lanes, refused addresses
    task t_regs;
        rd(CTL);
        chk(rdat, 32'h0);
        rd(TRG);
        chk(rdat, 32'h0);
        rd(TSL);
        chk(rdat, 32'h5);
        wr(TSL, 32'hff);
        rd(TSL);
        chk(rdat, 32'hf);
        wr(TSL, 32'h5);
        wr(CTL, 32'h3f);
        rd(CTL);
        chk(rdat, 32'h1f);
        wr(VAL, 32'h1234);
        apb(1'b1, VAL, 32'hab, 4'h1);
        rd(VAL);
        chk(rdat, 32'h12ab);
        rd(VAL + 16'h2);
        chk({rdat[30:0], rerr}, 32'h1);
        rd(16'h1034);
        chk({rdat[30:0], rerr}, 32'h1);
    endtask
    // edge modes, prescaled modes and every trigger source
    task t_capture;
        run <= 1'b1;
        repeat (7) @(posedge clk);
        run <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wr(CTL, 32'h83 + k);
            step(13'h1);
            chk(n_flag, k != 1);
            step(13'h0);
            chk(n_flag, k != 2);
        end
        rd(VAL);
        chk(rdat, {16'h0, tmr});
        for (int j = 0; j < 2; j++) begin
            wr(CTL, 32'h80);
            wr(CTL, 32'h86 + j);
            acc = 0;
            repeat (j ? 16 : 4) begin
                step(13'h1);
                acc += n_flag;
                step(13'h0);
            end
            chk(acc, 1);
        end
        wr(CTL, 32'h85);
        for (int c = 0; c < 14; c++) begin
            wr(TRG, c);
            step(c < 13 ? 13'h1 << c : 13'h1fff);
            chk(n_flag, c < 13);
            step(13'h0);
        end
    endtask
    // compare actions; the 1011 pulse and 0001 toggle modes clear the timer at each match
    task t_compare;
        wr(VAL, 32'h10);
        run <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(CTL, m ? 32'h81 : 32'h8b);
            watch(80);
            chk(m ? n_tog : n_hi, n_clr);
            chk(n_flag, n_clr);
            chk(n_clr > 2, 1);
        end
        for (int m = 0; m < 3; m++) begin
            wr(VAL, {16'h0, tmr + 16'h20});
            wr(CTL, m == 1 ? 32'h89 : 32'h88);
            watch(60);
            rd(CTL);
            chk(rdat, m == 1 ? 32'h89 : 32'ha8);
        end
        wr(CTL, 32'h80);
        rd(CTL);
        chk({rdat[30:0], cout[0]}, 32'h100);
    endtask
    // right aligned, zero duty, left aligned under another 11xx code
    task t_pwm;
        for (int p = 0; p < 3; p++) begin
            wr(VAL, p == 0 ? 32'h6 : p == 1 ? 32'h0 : 32'h180);
            wr(CTL, p == 0 ? 32'h8c : p == 1 ? 32'h8d : 32'h9f);
            watch(40);
            watch(32);
            chk(n_hi, p == 1 ? 0 : 12);
            chk(n_flag, 2);
        end
    endtask
    // prints the counts and the verdict, then stops
    task tally_and_finish;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        $display("registers done");
        t_capture;
        $display("capture done");
        t_compare;
        $display("compare done");
        t_pwm;
        $display("pwm done");
        tally_and_finish;
    end
    // a hang ends in the closing task as a failure
    initial begin
        #(25 * 20000);
        num_errors++;
        tally_and_finish;
    end
endmodule
bind ccp_unit ccp_unit_monitor i_ccp_unit_monitor (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr),
    .period_timer_count(period_timer_count), .period_value(period_value),
    .period_timer_inc(period_timer_inc), .sixteen_bit_timer_clear(sixteen_bit_timer_clear),
    .period_timer_clear(period_timer_clear), .channel_out(channel_out),
    .channel_interrupt_flag(channel_interrupt_flag));
`default_nettype wire
